// ===== core/aerr_pkg.sv
// aerr_pkg: offsets, field masks and reset values of the
// per-port error reporting register bank
// assumes a 32-bit APB slave and event sources on pclk
//
// How it works
// - severity bit per type, listed ones reset fatal
// - timeout, abort, completion, request, access reset nonfatal
// - surprise down counts on downstream ports only
// - receiver, bad packet, bad link: sticky W1C
// - rollover, replay timeout, advisory: sticky W1C
// - correctable status resets to zero
// - masked correctable event: status bit set, no message
// - advisory mask resets set, others clear
// - five-bit first-error pointer, resets zero
// - CRC generate capable bit reads one
// - sticky CRC generate enable, resets zero
// - CRC check capable bit reads one
// - sticky CRC check enable, resets zero
// - four sticky header doublewords, first lowest
// - header bytes big-endian within each doubleword
// - uncorrectable status sticky W1C, pointer indexes it
// - masked uncorrectable event: status bit set, no header log, no message
package aerr_pkg;

    // ==================================================
    // bus geometry
    localparam int unsigned AW         = 12;
    localparam int unsigned DW         = 32;
    localparam int unsigned LANE_BITS  = 2;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned WORD_BYTES = 4;
    localparam int unsigned HLOG_WORDS = 4;
    localparam int unsigned HLOG_IW    = 2;
    localparam int unsigned HLOG_BITS  = 128;

    // ==================================================
    // register byte offsets
    localparam logic [AW-1:0] OFF_UNC_STS = 12'h104;
    localparam logic [AW-1:0] OFF_UNC_MSK = 12'h108;
    localparam logic [AW-1:0] OFF_UNC_SEV = 12'h10c;
    localparam logic [AW-1:0] OFF_COR_STS = 12'h110;
    localparam logic [AW-1:0] OFF_COR_MSK = 12'h114;
    localparam logic [AW-1:0] OFF_CTL     = 12'h118;
    localparam logic [AW-1:0] OFF_HLOG0   = 12'h11c;
    localparam logic [AW-1:0] OFF_HLOG3   = 12'h128;

    // ==================================================
    // implemented bits and reset values
    localparam logic [DW-1:0] ZERO        = 32'h0000_0000;
    localparam logic [DW-1:0] UNC_IMPL    = 32'h003f_f031;
    localparam logic [DW-1:0] UNC_SEV_RST = 32'h0006_2031;
    localparam logic [DW-1:0] UNC_MSK_RST = 32'h0000_0000;
    localparam logic [DW-1:0] COR_IMPL    = 32'h0000_31c1;
    localparam logic [DW-1:0] COR_STS_RST = 32'h0000_0000;
    localparam logic [DW-1:0] COR_MSK_RST = 32'h0000_2000;
    localparam logic [DW-1:0] CTL_WMASK   = 32'h0000_0140;
    localparam logic [DW-1:0] CTL_CAP     = 32'h0000_00a0;
    localparam logic [DW-1:0] CTL_RST     = 32'h0000_0000;
    localparam int unsigned   FEP_W       = 5;
    localparam logic [FEP_W-1:0] FEP_RST  = 5'h00;

    // ==================================================
    // field positions
    localparam int unsigned B_SDN    = 5;
    localparam int unsigned B_GEN_EN = 6;
    localparam int unsigned B_CHK_EN = 8;

endpackage

// ===== core/aerr_hlog.sv
// aerr_hlog: four-doubleword header log with registered read
// assumes one write strobe per captured error, all on pclk
`timescale 1ns/1ps

module aerr_hlog import aerr_pkg::*; (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 wr_en,
    input  wire logic [HLOG_BITS-1:0] hdr_in,
    input  wire logic [HLOG_IW-1:0]   rd_idx,
    output logic      [DW-1:0]        rd_data
);

    logic [HLOG_WORDS-1:0][DW-1:0] word_ff;
    logic [HLOG_WORDS-1:0][DW-1:0] swapped;
    logic [DW-1:0]                 rd_ff;
    logic [BYTE_W-1:0]             first_byte;

    // ==================================================
    // byte order: arrival byte 0 lands in the top lane
    genvar g, b;
    generate
        for (g = 0; g < HLOG_WORDS; g++) begin : g_word
            for (b = 0; b < WORD_BYTES; b++) begin : g_byte
                assign swapped[g][DW-1-b*BYTE_W -: BYTE_W] =
                    hdr_in[(g*WORD_BYTES+b)*BYTE_W +: BYTE_W];
            end
        end
    endgenerate

    // power-on reset only: the log survives hot resets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_ff <= '0;
        end else if (wr_en) begin
            word_ff <= swapped;
        end
    end

    // read data leaves a flop, so the bus waits one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= ZERO;
        end else begin
            rd_ff <= word_ff[rd_idx];
        end
    end

    assign rd_data    = rd_ff;
    assign first_byte = hdr_in[BYTE_W-1:0];

    // ==================================================
    // checks
    hdr_be_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en |=> word_ff[0][DW-1 -: BYTE_W] == $past(first_byte))
        else $error("header byte 0 not in top lane");

    hlog_cap_c: cover property (@(posedge pclk) disable iff (!presetn)
        wr_en ##1 !wr_en);

endmodule // aerr_hlog

// ===== core/aerr_regs.sv
// aerr_regs: per-port error reporting registers on APB
// assumes events and packet header arrive on pclk as pulses,
// the port-type strap is a pin, hot_rst_n comes from pclk logic
`timescale 1ns/1ps

module aerr_regs import aerr_pkg::*; (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 hot_rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [AW-1:0]        paddr,
    input  wire logic [DW-1:0]        pwdata,
    output logic      [DW-1:0]        prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 dsp_strap,
    input  wire logic [DW-1:0]        unc_evt,
    input  wire logic [DW-1:0]        cor_evt,
    input  wire logic [HLOG_BITS-1:0] evt_hdr,
    output logic                      err_msg_cor,
    output logic                      err_msg_nonfatal,
    output logic                      err_msg_fatal,
    output logic                      ecrc_gen_en,
    output logic                      ecrc_chk_en
);

    // ==================================================
    // declarations
    logic             dsp_meta_ff;
    logic             dsp_ff;
    logic [DW-1:0]    unc_sts_ff;
    logic [DW-1:0]    unc_msk_ff;
    logic [DW-1:0]    unc_sev_ff;
    logic [DW-1:0]    cor_sts_ff;
    logic [DW-1:0]    cor_msk_ff;
    logic [DW-1:0]    ctl_ff;
    logic [FEP_W-1:0] fep_ff;
    logic             held_ff;
    logic             done_ff;
    logic [DW-1:0]    prdata_ff;
    logic             msg_cor_ff;
    logic             msg_nf_ff;
    logic             msg_f_ff;
    logic [DW-1:0]    unc_valid;
    logic [DW-1:0]    unc_hit;
    logic [DW-1:0]    unc_live;
    logic [DW-1:0]    cor_hit;
    logic [DW-1:0]    cor_live;
    logic [DW-1:0]    unc_w1c;
    logic [DW-1:0]    cor_w1c;
    logic [DW-1:0]    ctl_rd;
    logic [DW-1:0]    rd_mux;
    logic [DW-1:0]    hlog_rdata;
    logic [AW-1:0]    hlog_off;
    logic             acc;
    logic             wr_ok;
    logic             hit_hlog;
    logic             clr_fep;
    logic             cap;

    // ==================================================
    // helpers
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [AW-1:0] off);
        return a == off;
    endfunction

    // lowest set bit wins when several errors land at once
    function automatic logic [FEP_W-1:0] first_bit(
        input logic [DW-1:0] v);
        logic [FEP_W-1:0] p;
        p = FEP_RST;
        for (int i = DW-1; i >= 0; i--) begin
            if (v[i]) begin
                p = FEP_W'(i);
            end
        end
        return p;
    endfunction

    // ==================================================
    // port-type strap: two flops, first read only by second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dsp_meta_ff <= 1'b0;
            dsp_ff      <= 1'b0;
        end else begin
            dsp_meta_ff <= dsp_strap;
            dsp_ff      <= dsp_meta_ff;
        end
    end

    // ==================================================
    // event qualification
    // surprise down is dropped on the upstream port
    assign unc_valid = dsp_ff ? UNC_IMPL
                              : (UNC_IMPL & ~(ZERO | (1 << B_SDN)));
    assign unc_hit   = unc_evt & unc_valid;
    assign unc_live  = unc_hit & ~unc_msk_ff;
    assign cor_hit   = cor_evt & COR_IMPL;
    assign cor_live  = cor_hit & ~cor_msk_ff;

    // ==================================================
    // APB slave: two access cycles, write lands at pready
    assign acc      = psel & penable;
    assign hlog_off = paddr - OFF_HLOG0;
    assign hit_hlog = (paddr >= OFF_HLOG0) && (paddr <= OFF_HLOG3)
                    && (paddr[LANE_BITS-1:0] == '0);
    assign pready   = acc & done_ff;
    assign pslverr  = pready
                    & ~(hit_hlog | hit(paddr, OFF_UNC_STS)
                      | hit(paddr, OFF_UNC_MSK) | hit(paddr, OFF_UNC_SEV)
                      | hit(paddr, OFF_COR_STS) | hit(paddr, OFF_COR_MSK)
                      | hit(paddr, OFF_CTL));
    assign wr_ok    = pready & pwrite & ~pslverr;
    assign unc_w1c  = (wr_ok && hit(paddr, OFF_UNC_STS)) ? pwdata : ZERO;
    assign cor_w1c  = (wr_ok && hit(paddr, OFF_COR_STS)) ? pwdata : ZERO;

    // wait-state flag; a hot reset holds pready low, the transfer completes after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'b0;
        end else if (!hot_rst_n) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= acc & ~done_ff;
        end
    end

    // read mux; reserved bits are never stored, so read zero
    assign ctl_rd = CTL_CAP | ctl_ff | DW'(fep_ff);
    always_comb begin
        rd_mux = ZERO;
        case (paddr)
            OFF_UNC_STS: rd_mux = unc_sts_ff;
            OFF_UNC_MSK: rd_mux = unc_msk_ff;
            OFF_UNC_SEV: rd_mux = unc_sev_ff;
            OFF_COR_STS: rd_mux = cor_sts_ff;
            OFF_COR_MSK: rd_mux = cor_msk_ff;
            OFF_CTL:     rd_mux = ctl_rd;
            default: begin
                if (hit_hlog) begin
                    rd_mux = hlog_rdata;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= ZERO;
        end else if (acc && !done_ff) begin
            prdata_ff <= pwrite ? ZERO : rd_mux;
        end
    end

    // ==================================================
    // sticky registers: power-on reset only, hot reset ignored
    // software fields; reserved bits masked off on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unc_sev_ff <= UNC_SEV_RST;
            unc_msk_ff <= UNC_MSK_RST;
            cor_msk_ff <= COR_MSK_RST;
            ctl_ff     <= CTL_RST;
        end else if (wr_ok) begin
            if (hit(paddr, OFF_UNC_SEV)) begin
                unc_sev_ff <= pwdata & UNC_IMPL;
            end
            if (hit(paddr, OFF_UNC_MSK)) begin
                unc_msk_ff <= pwdata & UNC_IMPL;
            end
            if (hit(paddr, OFF_COR_MSK)) begin
                cor_msk_ff <= pwdata & COR_IMPL;
            end
            if (hit(paddr, OFF_CTL)) begin
                ctl_ff <= pwdata & CTL_WMASK;
            end
        end
    end

    // status bits: an event in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unc_sts_ff <= ZERO;
            cor_sts_ff <= COR_STS_RST;
        end else begin
            unc_sts_ff <= (unc_sts_ff & ~unc_w1c) | unc_hit;
            cor_sts_ff <= (cor_sts_ff & ~cor_w1c) | cor_hit;
        end
    end

    // ==================================================
    // first error capture: log is free again once software
    // clears the status bit the pointer names
    assign clr_fep = unc_w1c[fep_ff] & held_ff;
    assign cap     = (|unc_live) & (~held_ff | clr_fep);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_ff <= 1'b0;
            fep_ff  <= FEP_RST;
        end else if (cap) begin
            held_ff <= 1'b1;
            fep_ff  <= first_bit(unc_live);
        end else if (clr_fep) begin
            held_ff <= 1'b0;
        end
    end

    aerr_hlog u_hlog (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (cap),
        .hdr_in  (evt_hdr),
        .rd_idx  (hlog_off[LANE_BITS +: HLOG_IW]),
        .rd_data (hlog_rdata)
    );

    // ==================================================
    // upstream messages, one-cycle pulses per event cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_cor_ff <= 1'b0;
            msg_nf_ff  <= 1'b0;
            msg_f_ff   <= 1'b0;
        end else if (!hot_rst_n) begin
            msg_cor_ff <= 1'b0;
            msg_nf_ff  <= 1'b0;
            msg_f_ff   <= 1'b0;
        end else begin
            msg_cor_ff <= |cor_live;
            msg_nf_ff  <= |(unc_live & ~unc_sev_ff);
            msg_f_ff   <= |(unc_live & unc_sev_ff);
        end
    end

    assign prdata           = prdata_ff;
    assign err_msg_cor      = msg_cor_ff;
    assign err_msg_nonfatal = msg_nf_ff;
    assign err_msg_fatal    = msg_f_ff;
    assign ecrc_gen_en      = ctl_ff[B_GEN_EN];
    assign ecrc_chk_en      = ctl_ff[B_CHK_EN];

    // ==================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    cor_set_a: assert property ((|cor_hit) |=>
        (cor_sts_ff & $past(cor_hit)) == $past(cor_hit))
        else $error("correctable status not set");

    cor_mask_a: assert property (
        (|cor_hit) && !(|cor_live) |=> !err_msg_cor)
        else $error("masked correctable sent message");

    unc_mask_a: assert property (
        (|unc_hit) && !(|unc_live)
        |=> !err_msg_fatal && !err_msg_nonfatal)
        else $error("masked uncorrectable sent message");

    up_sdn_a: assert property (
        !dsp_ff && !unc_sts_ff[B_SDN] |=> !unc_sts_ff[B_SDN])
        else $error("surprise down logged on upstream port");

    fep_hold_a: assert property (
        held_ff && !clr_fep |=> held_ff && $stable(fep_ff))
        else $error("first error pointer overwritten");

    cap_bits_a: assert property (
        pready && !pwrite && hit(paddr, OFF_CTL)
        |-> (prdata & CTL_CAP) == CTL_CAP)
        else $error("capability bits not one");

    rsvd_zero_a: assert property (
        pready && !pwrite && hit(paddr, OFF_COR_STS)
        |-> (prdata & ~COR_IMPL) == ZERO)
        else $error("reserved status bits not zero");

    ctl_wr_a: assert property (
        wr_ok && hit(paddr, OFF_CTL)
        |=> ctl_ff == ($past(pwdata) & CTL_WMASK))
        else $error("enable write not applied");

    apb_wait_a: assert property (
        psel && !penable ##1 acc && hot_rst_n |-> !pready ##1 pready)
        else $error("access phase not two cycles");

    fatal_c: cover property (err_msg_fatal);
    capture_c: cover property (cap ##[1:20] clr_fep);
    w1c_c: cover property ((|cor_w1c) ##1 (cor_sts_ff == ZERO));
    slverr_c: cover property (pslverr);

endmodule // aerr_regs

// ===== sim/aerr_rc_model.sv
// aerr_rc_model: root complex side, counts received error messages
// assumes one-cycle message pulses on pclk from the register bank
`timescale 1ns/1ps

module aerr_rc_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        err_msg_cor,
    input  wire logic        err_msg_nonfatal,
    input  wire logic        err_msg_fatal,
    output logic      [15:0] n_cor,
    output logic      [15:0] n_nf,
    output logic      [15:0] n_fat
);
    // ==================================================
    // message intake
    // one pulse is one message; a pulse held two cycles counts twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_cor <= '0;
            n_nf  <= '0;
            n_fat <= '0;
        end else begin
            n_cor <= n_cor + 16'(err_msg_cor);
            n_nf  <= n_nf + 16'(err_msg_nonfatal);
            n_fat <= n_fat + 16'(err_msg_fatal);
        end
    end
endmodule // aerr_rc_model

// ===== sim/tb_top.sv
// tb_top: register and event checks of the error reporting bank
// assumes aerr_regs as DUT, APB master here, root complex model beside
`timescale 1ns/1ps

module tb_top import aerr_pkg::*;;
    // ==================================================
    // stimulus and observation signals
    logic              pclk      = 1'b0;
    logic              presetn   = 1'b0;
    logic              hot_rst_n = 1'b1;
    logic              psel      = 1'b0;
    logic              penable   = 1'b0;
    logic              pwrite    = 1'b0;
    logic [AW-1:0]     paddr     = '0;
    logic [DW-1:0]     pwdata    = '0;
    logic              dsp_strap = 1'b1;
    logic [DW-1:0]     unc_evt   = '0;
    logic [DW-1:0]     cor_evt   = '0;
    logic [127:0]      evt_hdr   = '0;
    logic [DW-1:0]     prdata;
    logic              pready;
    logic              pslverr;
    logic              m_cor;
    logic              m_nf;
    logic              m_fat;
    logic              gen_en;
    logic              chk_en;
    logic [15:0]       n_cor;
    logic [15:0]       n_nf;
    logic [15:0]       n_fat;
    int                miscompares = 0;
    int                cmp_count   = 0;
    int                cycles      = 0;
    int                e_cor       = 0;
    int                e_nf        = 0;
    int                e_fat       = 0;
    int                cb[6]       = '{0, 6, 7, 8, 12, 13};

    aerr_regs dut_u (.pclk(pclk), .presetn(presetn), .hot_rst_n(hot_rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dsp_strap(dsp_strap), .unc_evt(unc_evt),
        .cor_evt(cor_evt), .evt_hdr(evt_hdr), .err_msg_cor(m_cor),
        .err_msg_nonfatal(m_nf), .err_msg_fatal(m_fat),
        .ecrc_gen_en(gen_en), .ecrc_chk_en(chk_en));

    aerr_rc_model rc_u (.pclk(pclk), .presetn(presetn), .err_msg_cor(m_cor),
        .err_msg_nonfatal(m_nf), .err_msg_fatal(m_fat), .n_cor(n_cor),
        .n_nf(n_nf), .n_fat(n_fat));

    // ==================================================
    // clock and hang guard
    initial begin
        forever #50 pclk = ~pclk;
    end

    // ceiling far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    // ==================================================
    // shared tasks
    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // the request stands until a rising edge samples pready high; that
    // edge alone takes read data and response, then all is released;
    // a lost pready is caught by the cycle ceiling, not here
    task automatic apb(input logic wr, input logic [AW-1:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        chk("pready_wait", 32'h0000_0001, 32'(n));
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp,
                          input string nm);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(nm, exp, r);
    endtask

    // header byte k carries base+k; arrival byte k sits at [8k+7:8k]
    function automatic logic [127:0] hdr(input logic [7:0] base);
        for (int k = 0; k < 16; k++)
            hdr[8*k +: 8] = base + 8'(k);
    endfunction

    function automatic logic [31:0] hw(input logic [7:0] b, input int d);
        hw = {b + 8'(4*d), b + 8'(4*d+1), b + 8'(4*d+2), b + 8'(4*d+3)};
    endfunction

    // event pulse; header turned over afterwards so a late capture shows
    task automatic pulse(input logic [31:0] u, input logic [31:0] c,
                         input logic [127:0] h);
        @(posedge pclk);
        unc_evt <= u;
        cor_evt <= c;
        evt_hdr <= h;
        @(posedge pclk);
        unc_evt <= '0;
        cor_evt <= '0;
        evt_hdr <= ~h;
        repeat (2) @(posedge pclk);
    endtask

    task automatic chk_msgs;
        chk("msg_cor", 32'(e_cor), {16'h0, n_cor});
        chk("msg_nonfatal", 32'(e_nf), {16'h0, n_nf});
        chk("msg_fatal", 32'(e_fat), {16'h0, n_fat});
    endtask

    // ==================================================
    // scenarios
    task automatic t_reset;
        chk("gen_en_rst", 32'h0000_0000, {31'h0, gen_en});
        chk("chk_en_rst", 32'h0000_0000, {31'h0, chk_en});
        rd_chk(OFF_UNC_STS, 32'h0000_0000, "unc_sts_rst");
        rd_chk(OFF_UNC_MSK, 32'h0000_0000, "unc_msk_rst");
        rd_chk(OFF_UNC_SEV, 32'h0006_2031, "unc_sev");
        rd_chk(OFF_COR_STS, 32'h0000_0000, "cor_sts");
        rd_chk(OFF_COR_MSK, 32'h0000_2000, "cor_msk");
        rd_chk(OFF_CTL, 32'h0000_00a0, "ctl");
    endtask

    task automatic t_cor;
        logic [31:0] acc;
        acc = '0;
        foreach (cb[i]) begin
            pulse('0, 32'h0000_0001 << cb[i], '0);
            acc = acc | (32'h0000_0001 << cb[i]);
            if (cb[i] != 13)
                e_cor++;
            rd_chk(OFF_COR_STS, acc, "cor_sts");
            chk_msgs();
        end
        wr(OFF_COR_STS, 32'h0000_1041);
        rd_chk(OFF_COR_STS, 32'h0000_2180, "cor_sts");
        wr(OFF_COR_MSK, 32'hffff_ffff);
        rd_chk(OFF_COR_MSK, 32'h0000_31c1, "cor_msk");
        pulse('0, 32'h0000_0040, '0);
        chk_msgs();
        wr(OFF_COR_MSK, 32'h0000_2000);
        wr(OFF_COR_STS, 32'hffff_ffff);
        rd_chk(OFF_COR_STS, 32'h0000_0000, "cor_sts");
    endtask

    task automatic t_ctl;
        wr(OFF_CTL, 32'hffff_ffff);
        rd_chk(OFF_CTL, 32'h0000_01e0, "ctl");
        chk("gen_en", 32'h0000_0001, {31'h0, gen_en});
        chk("chk_en", 32'h0000_0001, {31'h0, chk_en});
        // ordinary reset must leave every sticky field alone
        @(posedge pclk);
        hot_rst_n <= 1'b0;
        repeat (2) @(posedge pclk);
        hot_rst_n <= 1'b1;
        rd_chk(OFF_CTL, 32'h0000_01e0, "ctl_hot");
        rd_chk(OFF_COR_MSK, 32'h0000_2000, "cor_msk_hot");
    endtask

    task automatic t_unc;
        wr(OFF_UNC_SEV, 32'hffff_ffff);
        rd_chk(OFF_UNC_SEV, 32'h003f_f031, "unc_sev");
        wr(OFF_UNC_SEV, 32'h0006_2031);
        pulse(32'h0004_0000, '0, hdr(8'h40));
        e_fat++;
        chk_msgs();
        rd_chk(OFF_UNC_STS, 32'h0004_0000, "unc_sts");
        rd_chk(OFF_CTL, 32'h0000_01f2, "fep");
        for (int d = 0; d < 4; d++)
            rd_chk(OFF_HLOG0 + 12'(4*d), hw(8'h40, d), "hlog");
        pulse(32'h0000_4000, '0, hdr(8'h80));
        e_nf++;
        chk_msgs();
        rd_chk(OFF_CTL, 32'h0000_01f2, "fep_held");
        rd_chk(OFF_HLOG0, hw(8'h40, 0), "hlog_held");
        wr(OFF_UNC_STS, 32'h0004_0000);
        rd_chk(OFF_UNC_STS, 32'h0000_4000, "unc_sts");
        pulse(32'h0000_4000, '0, hdr(8'h80));
        e_nf++;
        chk_msgs();
        rd_chk(OFF_CTL, 32'h0000_01ee, "fep_new");
        rd_chk(OFF_HLOG3, hw(8'h80, 3), "hlog_new");
        wr(OFF_UNC_STS, 32'hffff_ffff);
    endtask

    task automatic t_mask_sdn;
        logic [31:0] r;
        logic        e;
        wr(OFF_UNC_MSK, 32'h0000_1000);
        pulse(32'h0000_1000, '0, hdr(8'hc0));
        chk_msgs();
        rd_chk(OFF_UNC_STS, 32'h0000_1000, "unc_sts");
        rd_chk(OFF_HLOG0, hw(8'h80, 0), "hlog_masked");
        wr(OFF_UNC_MSK, 32'h0000_0000);
        wr(OFF_UNC_STS, 32'hffff_ffff);
        // upstream strap: surprise down must leave no trace
        @(posedge pclk);
        dsp_strap <= 1'b0;
        repeat (4) @(posedge pclk);
        pulse(32'h0000_0020, '0, hdr(8'h10));
        chk_msgs();
        rd_chk(OFF_UNC_STS, 32'h0000_0000, "sdn_up");
        @(posedge pclk);
        dsp_strap <= 1'b1;
        repeat (4) @(posedge pclk);
        pulse(32'h0000_0020, '0, hdr(8'h10));
        e_fat++;
        chk_msgs();
        rd_chk(OFF_UNC_STS, 32'h0000_0020, "sdn_down");
        wr(OFF_UNC_STS, 32'hffff_ffff);
        apb(1'b0, 12'h0200, 32'h0000_0000, r, e);
        chk("slverr", 32'h0000_0001, {31'h0, e});
    endtask

    // ==================================================
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cor();
        t_ctl();
        t_unc();
        t_mask_sdn();
        stop_test();
    end
endmodule // tb_top
